// File: ppg_pkg.sv
// Shared constants of the test-pattern generator: widths, pattern
// identifiers, polynomial tap masks, fixed frames and reset values.
// Assumes every file of the generator imports it whole.
package ppg_pkg;

   // ------------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------------
   localparam int PPG_ID_W     = 4;
   localparam int PPG_FRAME_W  = 20;
   localparam int PPG_WORD_W   = 10;
   localparam int PPG_NUM_PRBS = 10;
   localparam int PPG_MAX_ORD  = 32;
   localparam int PPG_SYNC_N   = 2;

   // ------------------------------------------------------------------
   // Pattern identifiers
   // ------------------------------------------------------------------
   localparam logic [PPG_ID_W-1:0] PPG_ID_CLK2   = 4'h0;
   localparam logic [PPG_ID_W-1:0] PPG_ID_CLK10  = 4'h1;
   localparam logic [PPG_ID_W-1:0] PPG_ID_CLK20  = 4'h2;
   localparam logic [PPG_ID_W-1:0] PPG_ID_PRBS7  = 4'h3;
   localparam logic [PPG_ID_W-1:0] PPG_ID_PRBS32 = 4'hc;
   localparam logic [PPG_ID_W-1:0] PPG_ID_USER   = 4'hd;
   localparam logic [PPG_ID_W-1:0] PPG_ID_RSV14  = 4'he;
   localparam logic [PPG_ID_W-1:0] PPG_ID_RSV15  = 4'hf;

   // ------------------------------------------------------------------
   // Polynomials, index 0 is identifier 3, index 9 is identifier 12.
   // Mask bit k-1 set means term x^k feeds back.
   // ------------------------------------------------------------------
   localparam int PPG_PRBS_ORDER [PPG_NUM_PRBS] = '{7, 9, 11, 15, 20, 20, 23, 29, 31, 32};
   localparam logic [PPG_MAX_ORD-1:0] PPG_PRBS_TAPS [PPG_NUM_PRBS] = '{
      32'h0000_0060,   // 1+x6+x7
      32'h0000_0110,   // 1+x5+x9
      32'h0000_0500,   // 1+x9+x11
      32'h0000_6000,   // 1+x14+x15
      32'h0008_0004,   // 1+x3+x20
      32'h0009_0000,   // 1+x17+x20
      32'h0042_0000,   // 1+x18+x23
      32'h1400_0000,   // 1+x27+x29
      32'h4800_0000,   // 1+x28+x31
      32'he000_0200    // 1+x10+x30+x31+x32
   };
   localparam logic PPG_PRBS_INV [PPG_NUM_PRBS] = '{1'h0, 1'h0, 1'h0, 1'h1, 1'h0,
                                                    1'h0, 1'h1, 1'h1, 1'h1, 1'h0};

   // ------------------------------------------------------------------
   // Fixed frames, bit 19 is sent first
   // ------------------------------------------------------------------
   localparam logic [PPG_FRAME_W-1:0] PPG_FRAME_CLK2  = 20'haaaaa;
   localparam logic [PPG_FRAME_W-1:0] PPG_FRAME_CLK10 = 20'hf83e0;
   localparam logic [PPG_FRAME_W-1:0] PPG_FRAME_CLK20 = 20'hffc00;
   localparam logic [PPG_FRAME_W-1:0] PPG_FRAME_IDLE  = 20'h00000;
   localparam logic [PPG_FRAME_W-1:0] PPG_FRAME_ONES  = 20'hfffff;

   // ------------------------------------------------------------------
   // Reset values, code bit a at position 9
   // ------------------------------------------------------------------
   localparam logic [PPG_WORD_W-1:0] PPG_K285_POS = 10'h305;
   localparam logic [PPG_WORD_W-1:0] PPG_K285_NEG = 10'h0fa;
   localparam logic [PPG_ID_W-1:0]   PPG_ID_RESET = 4'h0;

endpackage

// File: ppg_prbs.sv
// One pseudo-random sequence engine producing a full frame per clock.
// Assumes a reset already synchronised to clk.
module ppg_prbs
   import ppg_pkg::*;
#(
   parameter int                     ORDER    = 7,
   parameter logic [PPG_MAX_ORD-1:0] TAP_MASK = 32'h0000_0060,
   parameter logic                   INVERT   = 1'h0,
   parameter int                     FRAME_W  = 20
) (
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               rst_sync_n,
   // Control
   input  wire logic               restart,
   // Frame out
   output logic      [FRAME_W-1:0] frame_q
);

   localparam logic [ORDER-1:0] SEED = {ORDER{1'b1}};
   localparam logic [ORDER-1:0] MASK = TAP_MASK[ORDER-1:0];

   logic [ORDER-1:0]   state_q;
   logic [ORDER-1:0]   state_d;
   logic [FRAME_W-1:0] frame_d;

   // ------------------------------------------------------------------
   // Twenty serial steps unrolled, first bit into the top of the frame
   // ------------------------------------------------------------------
   always_comb begin
      logic [ORDER-1:0] st;
      logic             fb;
      st      = state_q;
      fb      = 1'b0;
      frame_d = '0;
      for (int k = 0; k < FRAME_W; k++) begin
         fb                   = ^(st & MASK);
         frame_d[FRAME_W-1-k] = fb ^ INVERT;
         st                   = {st[ORDER-2:0], fb};
      end
      state_d = st;
   end

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state_q <= SEED;
         frame_q <= '0;
      end else begin
         state_q <= restart ? SEED : state_d;
         frame_q <= frame_d;
      end
   end

endmodule

// File: ppg_clkpat.sv
// Clock-like and user-word frames, registered.
// Assumes a reset already synchronised to clk.
module ppg_clkpat
   import ppg_pkg::*;
(
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst_sync_n,
   // Selection and user words
   input  wire logic [PPG_ID_W-1:0]    pattern_select,
   input  wire logic [PPG_WORD_W-1:0]  user_word_first,
   input  wire logic [PPG_WORD_W-1:0]  user_word_second,
   // Frame out
   output logic      [PPG_FRAME_W-1:0] frame_q
);

   logic [PPG_FRAME_W-1:0] frame_d;

   always_comb begin
      case (pattern_select)
         PPG_ID_CLK2:  frame_d = PPG_FRAME_CLK2;
         PPG_ID_CLK10: frame_d = PPG_FRAME_CLK10;
         PPG_ID_CLK20: frame_d = PPG_FRAME_CLK20;
         PPG_ID_USER:  frame_d = {user_word_first, user_word_second};
         default:      frame_d = PPG_FRAME_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         frame_q <= '0;
      end else begin
         frame_q <= frame_d;
      end
   end

endmodule

// File: ppg_top.sv
// Top of the test-pattern generator: selection, user words, error
// insertion and the outgoing frame for the transmitters.
// Assumes clk is the transceiver parallel user clock; switches are
// asynchronous pins, menu signals come from logic on clk.

module ppg_top
   import ppg_pkg::*;
(
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   // Pattern selection
   input  wire logic [PPG_ID_W-1:0]    switch_select,
   input  wire logic [PPG_ID_W-1:0]    menu_select,
   input  wire logic                   menu_source,
   // User words
   input  wire logic                   user_word_load,
   input  wire logic [PPG_WORD_W-1:0]  user_word_first_in,
   input  wire logic [PPG_WORD_W-1:0]  user_word_second_in,
   // Error insertion
   input  wire logic                   error_insert,
   // Frame and status out
   output logic      [PPG_FRAME_W-1:0] tx_frame_q,
   output logic      [PPG_ID_W-1:0]    active_select_q,
   output logic                        reserved_select_q
);

   // ------------------------------------------------------------------
   // Decoding helpers
   // ------------------------------------------------------------------
   function automatic logic ppg_is_prbs(input logic [PPG_ID_W-1:0] id);
      ppg_is_prbs = (id >= PPG_ID_PRBS7) && (id <= PPG_ID_PRBS32);
   endfunction

   function automatic logic ppg_is_reserved(input logic [PPG_ID_W-1:0] id);
      ppg_is_reserved = (id == PPG_ID_RSV14) || (id == PPG_ID_RSV15);
   endfunction

   // ------------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------------
   logic rst_meta_q;
   logic rst_sync_n;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_n <= rst_meta_q;
      end
   end

   // ------------------------------------------------------------------
   // Switch synchroniser
   // ------------------------------------------------------------------
   logic [PPG_ID_W-1:0] sw_meta_q;
   logic [PPG_ID_W-1:0] sw_sync_q;

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         sw_meta_q <= PPG_ID_RESET;
         sw_sync_q <= PPG_ID_RESET;
      end else begin
         sw_meta_q <= switch_select;
         sw_sync_q <= sw_meta_q;
      end
   end

   // ------------------------------------------------------------------
   // Active selection
   // ------------------------------------------------------------------
   logic [PPG_ID_W-1:0] select_d;
   logic                select_change;
   logic [PPG_ID_W-1:0] prbs_sel_q;

   assign select_d      = menu_source ? menu_select : sw_sync_q;
   assign select_change = (select_d != active_select_q);

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         active_select_q   <= PPG_ID_RESET;
         reserved_select_q <= 1'b0;
         prbs_sel_q        <= PPG_ID_RESET;
      end else begin
         active_select_q   <= select_d;
         reserved_select_q <= ppg_is_reserved(select_d);
         prbs_sel_q        <= active_select_q;
      end
   end

   // ------------------------------------------------------------------
   // User words
   // ------------------------------------------------------------------
   logic [PPG_WORD_W-1:0] user_first_q;
   logic [PPG_WORD_W-1:0] user_second_q;

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         user_first_q  <= PPG_K285_POS;
         user_second_q <= PPG_K285_NEG;
      end else if (user_word_load) begin
         user_first_q  <= user_word_first_in;
         user_second_q <= user_word_second_in;
      end
   end

   // ------------------------------------------------------------------
   // Sequence engines, reseeded when a new pattern is chosen
   // ------------------------------------------------------------------
   logic [PPG_FRAME_W-1:0] prbs_frame [PPG_NUM_PRBS];
   logic                   restart_q;

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         restart_q <= 1'b0;
      end else begin
         restart_q <= select_change;
      end
   end

   // Identifier 8 runs unmodified, its zero runs are not clipped
   for (genvar g = 0; g < PPG_NUM_PRBS; g++) begin : g_prbs
      ppg_prbs #(
         .ORDER    (PPG_PRBS_ORDER[g]),
         .TAP_MASK (PPG_PRBS_TAPS[g]),
         .INVERT   (PPG_PRBS_INV[g]),
         .FRAME_W  (PPG_FRAME_W)
      ) u_prbs (
         .clk        (clk),
         .rst_sync_n (rst_sync_n),
         .restart    (restart_q),
         .frame_q    (prbs_frame[g])
      );
   end

   // ------------------------------------------------------------------
   // Clock-like and user frames
   // ------------------------------------------------------------------
   logic [PPG_FRAME_W-1:0] fixed_frame;

   ppg_clkpat u_clkpat (
      .clk              (clk),
      .rst_sync_n       (rst_sync_n),
      .pattern_select   (active_select_q),
      .user_word_first  (user_first_q),
      .user_word_second (user_second_q),
      .frame_q          (fixed_frame)
   );

   // ------------------------------------------------------------------
   // Frame selection and error insertion
   // ------------------------------------------------------------------
   logic [PPG_ID_W-1:0]    prbs_index;
   logic [PPG_FRAME_W-1:0] sel_frame;
   logic [PPG_FRAME_W-1:0] err_mask;

   assign prbs_index = prbs_sel_q - PPG_ID_PRBS7;
   assign sel_frame  = ppg_is_prbs(prbs_sel_q) ? prbs_frame[prbs_index] : fixed_frame;
   assign err_mask   = error_insert ? PPG_FRAME_ONES : PPG_FRAME_IDLE;

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         tx_frame_q <= '0;
      end else begin
         tx_frame_q <= sel_frame ^ err_mask;
      end
   end

endmodule

// File: ppg_top_asserts.sv
// Concurrent checks on the ports of the pattern generator top.
// Assumes it is bound to ppg_top and that clk is the only clock.
module ppg_top_asserts
   import ppg_pkg::*;
(
   // Observed ports
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   input  wire logic [PPG_ID_W-1:0]    switch_select,
   input  wire logic [PPG_ID_W-1:0]    menu_select,
   input  wire logic                   menu_source,
   input  wire logic                   error_insert,
   input  wire logic [PPG_FRAME_W-1:0] tx_frame_q,
   input  wire logic [PPG_ID_W-1:0]    active_select_q,
   input  wire logic                   reserved_select_q
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [1:0]             up_q;
   logic                   ready;
   logic [PPG_FRAME_W-1:0] fix_exp;

   // Skips the reset release through the synchroniser
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         up_q <= 2'h0;
      end else if (up_q != 2'h3) begin
         up_q <= up_q + 2'h1;
      end
   end
   assign ready   = (up_q == 2'h3);
   assign fix_exp = (active_select_q == 4'h0) ? 20'haaaaa :
                    (active_select_q == 4'h1) ? 20'hf83e0 : 20'hffc00;

   default clocking cb @(posedge clk); endclocking

   sequence held_id;
      ready ##0 $stable(active_select_q)[*3];
   endsequence
   sequence held_long;
      ready ##0 $stable(active_select_q)[*6];
   endsequence

   // Second edge in reset: the first still sees flops before the synchronised reset lands
   rst_out_a:
      assert property (!rst_n ##1 !rst_n |-> tx_frame_q == '0 && active_select_q == '0
         && !reserved_select_q)
      else $error("outputs not cleared in reset");
   sel_menu_a:
      assert property (disable iff (!rst_n)
         ready && menu_source |=> active_select_q == $past(menu_select))
      else $error("selection does not follow menu");
   sel_switch_a:
      assert property (disable iff (!rst_n)
         ready ##0 (!menu_source)[*4] |-> active_select_q == $past(switch_select, 3))
      else $error("selection does not follow switches");
   rsv_flag_a:
      assert property (disable iff (!rst_n)
         ready |-> reserved_select_q == (active_select_q >= 4'he))
      else $error("reserved flag wrong");
   rsv_zero_a:
      assert property (disable iff (!rst_n)
         ready ##0 reserved_select_q[*3] ##0 !$past(error_insert) |-> tx_frame_q == '0)
      else $error("reserved selection frame not zero");
   clk_fix_a:
      assert property (disable iff (!rst_n) held_id ##0 active_select_q < 4'h3
         ##0 !$past(error_insert) |-> tx_frame_q == fix_exp)
      else $error("clock pattern frame wrong");
   err_inv_a:
      assert property (disable iff (!rst_n) held_id ##0 active_select_q == 4'h2
         ##0 error_insert |=> tx_frame_q == 20'h003ff)
      else $error("error frame not inverted");
   prbs_adv_a:
      assert property (disable iff (!rst_n) held_long ##0 active_select_q inside {[3:12]}
         ##0 !error_insert && !$past(error_insert) |=> tx_frame_q != $past(tx_frame_q))
      else $error("sequence frame did not advance");
endmodule

// File: ppg_tx_model.sv
// Transmitter side of the generator: takes one frame every clock.
// Assumes the frame is sampled on the user clock rising edge.
module ppg_tx_model
   import ppg_pkg::*;
(
   // Clock
   input  wire logic                     clk,
   // Frame from the generator
   input  wire logic [PPG_FRAME_W-1:0]   tx_frame_q,
   // Two latest frames, newest in the low half
   output logic      [2*PPG_FRAME_W-1:0] hist_q
);
   timeunit 1ns;
   timeprecision 1ps;

   always_ff @(posedge clk) begin
      hist_q <= {hist_q[PPG_FRAME_W-1:0], tx_frame_q};
   end
endmodule

// File: tb_ppg_top.sv
// Self-checking bench of the pattern generator top.
// Assumes ppg_pkg, ppg_top, the checker and the transmitter model.
module tb_ppg_top;
   timeunit 1ns;
   timeprecision 1ps;
   import ppg_pkg::*;

   logic                     clk = 1'h0;
   logic                     rst_n = 1'h0;
   logic [PPG_ID_W-1:0]      switch_select = 4'h0;
   logic [PPG_ID_W-1:0]      menu_select = 4'h0;
   logic                     menu_source = 1'h1;
   logic                     user_word_load = 1'h0;
   logic [PPG_WORD_W-1:0]    user_word_first_in = 10'h000;
   logic [PPG_WORD_W-1:0]    user_word_second_in = 10'h000;
   logic                     error_insert = 1'h0;
   logic [PPG_FRAME_W-1:0]   tx_frame_q;
   logic [PPG_ID_W-1:0]      active_select_q;
   logic                     reserved_select_q;
   logic [2*PPG_FRAME_W-1:0] hist_q;
   int                       miscompares = 0;
   int                       cmp_count = 0;
   int                       cycles = 0;
   logic [PPG_FRAME_W-1:0]   fix [3] = '{20'haaaaa, 20'hf83e0, 20'hffc00};

   always #2.5 clk = ~clk;

   ppg_top u_dut (.clk(clk), .rst_n(rst_n), .switch_select(switch_select),
      .menu_select(menu_select), .menu_source(menu_source),
      .user_word_load(user_word_load), .user_word_first_in(user_word_first_in),
      .user_word_second_in(user_word_second_in), .error_insert(error_insert),
      .tx_frame_q(tx_frame_q), .active_select_q(active_select_q),
      .reserved_select_q(reserved_select_q));
   ppg_tx_model u_tx (.clk(clk), .tx_frame_q(tx_frame_q), .hist_q(hist_q));

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk_frame(input logic [PPG_FRAME_W-1:0] got, input logic [PPG_FRAME_W-1:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_sel(input logic [PPG_ID_W-1:0] got, input logic [PPG_ID_W-1:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic pick(input logic [PPG_ID_W-1:0] id);
      menu_select = id;
      menu_source = 1'h1;
      step(8);
   endtask
   // Next frame from the last 32 sent bits, first bit at position 19
   function automatic logic [PPG_FRAME_W-1:0] nxt(input logic [2*PPG_FRAME_W-1:0] h,
                                                   input int i);
      logic [31:0]            s;
      logic                   fb;
      logic [PPG_FRAME_W-1:0] f;
      s = h[31:0] ^ {32{PPG_PRBS_INV[i]}};
      for (int k = PPG_FRAME_W - 1; k >= 0; k--) begin
         fb   = ^(s & PPG_PRBS_TAPS[i]);
         f[k] = fb ^ PPG_PRBS_INV[i];
         s    = {s[30:0], fb};
      end
      return f;
   endfunction

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic t_reset();
      step(3);
      chk_frame(tx_frame_q, 20'h00000);
      chk_sel(active_select_q, 4'h0);
      step(3);
      rst_n = 1'h1;
      step(4);
   endtask
   task automatic t_user();
      pick(PPG_ID_USER);
      chk_frame(tx_frame_q, {10'h305, 10'h0fa});
      user_word_first_in  = 10'h2a5;
      user_word_second_in = 10'h1c3;
      user_word_load      = 1'h1;
      step(1);
      user_word_load     = 1'h0;
      user_word_first_in = 10'h000;
      step(4);
      chk_frame(tx_frame_q, {10'h2a5, 10'h1c3});
   endtask
   // Mid-run reset: frames clear, user words fall back to their defaults
   task automatic t_rerun();
      rst_n = 1'h0;
      step(2);
      chk_frame(tx_frame_q, PPG_FRAME_IDLE);
      rst_n = 1'h1;
      step(8);
      chk_frame(tx_frame_q, {PPG_K285_POS, PPG_K285_NEG});
   endtask
   task automatic t_fixed();
      for (int i = 0; i < 3; i++) begin
         pick(4'(i));
         chk_frame(tx_frame_q, fix[i]);
         step(1);
         chk_frame(tx_frame_q, fix[i]);
      end
   endtask
   task automatic t_prbs();
      for (int i = 0; i < PPG_NUM_PRBS; i++) begin
         pick(4'(i + 3));
         chk_sel(active_select_q, 4'(i + 3));
         for (int r = 0; r < 3; r++) begin
            if (PPG_PRBS_INV[i]) begin
               chk_frame(tx_frame_q, nxt(hist_q, i));
            end else begin
               chk_frame(tx_frame_q, nxt(hist_q, i));
            end
            step(1);
         end
      end
   endtask
   task automatic t_reserved();
      for (int i = 14; i < 16; i++) begin
         pick(4'(i));
         chk_frame(tx_frame_q, 20'h00000);
         chk_sel({3'h0, reserved_select_q}, 4'h1);
      end
   endtask
   task automatic t_error();
      pick(PPG_ID_CLK20);
      chk_sel({3'h0, reserved_select_q}, 4'h0);
      error_insert = 1'h1;
      step(1);
      error_insert = 1'h0;
      chk_frame(tx_frame_q, 20'h003ff);
      step(1);
      chk_frame(tx_frame_q, 20'hffc00);
   endtask
   task automatic t_switch();
      switch_select = 4'h1;
      menu_source   = 1'h0;
      step(8);
      chk_sel(active_select_q, 4'h1);
      chk_frame(tx_frame_q, 20'hf83e0);
      menu_source = 1'h1;
      step(8);
      chk_sel(active_select_q, 4'h2);
   endtask

   task automatic finish_test();
      $display("Compares %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         miscompares++;
         finish_test();
      end
   end

   initial begin
      t_reset();
      t_user();
      t_rerun();
      t_fixed();
      t_prbs();
      t_reserved();
      t_error();
      t_switch();
      finish_test();
   end
endmodule

bind ppg_top ppg_top_asserts u_chk (.clk(clk), .rst_n(rst_n), .switch_select(switch_select),
   .menu_select(menu_select), .menu_source(menu_source), .error_insert(error_insert),
   .tx_frame_q(tx_frame_q), .active_select_q(active_select_q),
   .reserved_select_q(reserved_select_q));
